/* File: rtl/dhs_if.sv */
`timescale 1ns/1ns
interface dhs_if;
    // transfer pair: request from initiator, completion from server
    logic transfer_request_toggle;
    logic transfer_complete_toggle;
    // termination pair: independent, used to abort (drop lock)
    logic terminate_request_toggle;
    logic terminate_complete_toggle;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport initiator (
        output transfer_request_toggle,
        output terminate_request_toggle,
        output wr_data,
        input transfer_complete_toggle,
        input terminate_complete_toggle,
        input rd_data
    );
    modport server (
        input transfer_request_toggle,
        input terminate_request_toggle,
        input wr_data,
        output transfer_complete_toggle,
        output terminate_complete_toggle,
        output rd_data
    );
endinterface : dhs_if

/* File: rtl/dhs_initiator.sv */
`timescale 1ns/1ns
// initiating end: the test unit bus master side
module dhs_initiator (
    input wire logic clock_in,
    input wire logic rst_b_in,
    dhs_if.initiator link,
    // serial command decoder: register address strobe
    input wire logic cmd_read_strobe_in,
    input wire logic [3:0] cmd_addr_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic drop_lock_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] result_out
);
    typedef enum logic [1:0] {
        DHS_IDLE = 2'h1,
        DHS_WAIT = 2'h2
    } dhs_ini_t;

    dhs_ini_t st_q, st_d;
    logic req_q, req_d, trm_q, trm_d;
    logic cmp_s1_q, cmp_s2_q, tcm_s1_q, tcm_s2_q;
    logic done_q, done_d;
    logic [7:0] res_q, res_d, wd_q, wd_d;

    // -------------------------------------------
    // completion synchronisers
    // -------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmp_s1_q <= dhs_pkg::TOGGLE_RST;
            cmp_s2_q <= dhs_pkg::TOGGLE_RST;
            tcm_s1_q <= dhs_pkg::TOGGLE_RST;
            tcm_s2_q <= dhs_pkg::TOGGLE_RST;
        end else begin
            cmp_s1_q <= link.transfer_complete_toggle;
            cmp_s2_q <= cmp_s1_q;
            tcm_s1_q <= link.terminate_complete_toggle;
            tcm_s2_q <= tcm_s1_q;
        end
    end

    // -------------------------------------------
    // request toggles
    // -------------------------------------------
    always_comb begin
        st_d = st_q;
        req_d = req_q;
        trm_d = trm_q;
        done_d = 1'b0;
        res_d = res_q;
        wd_d = wd_q;
        unique case (st_q)
            DHS_IDLE: begin
                if (cmd_read_strobe_in && cmd_addr_in == dhs_pkg::EXEC_REG_ADDR) begin
                    req_d = ~cmp_s2_q;
                    wd_d = cmd_data_in;
                    st_d = DHS_WAIT;
                end
            end
            DHS_WAIT: begin
                if (req_q == cmp_s2_q) begin
                    done_d = 1'b1;
                    res_d = link.rd_data;
                    st_d = DHS_IDLE;
                end
            end
            default: st_d = DHS_IDLE;
        endcase
        if (drop_lock_in && trm_q == tcm_s2_q) begin
            trm_d = ~tcm_s2_q;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= DHS_IDLE;
            req_q <= dhs_pkg::TOGGLE_RST;
            trm_q <= dhs_pkg::TOGGLE_RST;
            done_q <= 1'b0;
            res_q <= dhs_pkg::DATA_RST;
            wd_q <= dhs_pkg::DATA_RST;
        end else begin
            st_q <= st_d;
            req_q <= req_d;
            trm_q <= trm_d;
            done_q <= done_d;
            res_q <= res_d;
            wd_q <= wd_d;
        end
    end

    assign link.transfer_request_toggle = req_q;
    assign link.terminate_request_toggle = trm_q;
    assign link.wr_data = wd_q;
    assign busy_out = st_q[1];
    assign done_out = done_q;
    assign result_out = res_q;
endmodule : dhs_initiator

/* File: rtl/dhs_pkg.sv */
package dhs_pkg;
    // fixed-delay synchronizer: 3-bit free-running counter, 9..17 ticks
    localparam int unsigned FDS_CNT_W = 3;
    localparam logic [2:0] FDS_CNT_RST = 3'h0;
    localparam logic [2:0] FDS_SMP_AT = 3'h7;
    localparam logic [2:0] FDS_OUT_AT = 3'h0;
    localparam int unsigned FDS_MIN_TICKS = 9;
    localparam int unsigned FDS_MAX_TICKS = 17;
    localparam int unsigned FDS_HOLD_TICKS = 17;
    // variable-delay synchronizer settle stages
    localparam int unsigned VDS_STAGES = 4;
    localparam logic [1:0] VDS_PHASE_RST = 2'h0;
    // serial command register address that triggers execute
    localparam logic [3:0] EXEC_REG_ADDR = 4'h8;
    localparam int unsigned OP_CYCLES = 4;
    localparam logic [2:0] OP_CNT_RST = 3'h0;
    localparam logic [2:0] OP_CNT_LAST = 3'h3;
    localparam logic TOGGLE_RST = 1'b0;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;
endpackage : dhs_pkg

/* File: rtl/dhs_server.sv */
`timescale 1ns/1ns
module dhs_server (
    input wire logic clock_in,
    input wire logic rst_b_in,
    dhs_if.server link,
    input wire logic main_reset_n_in,
    input wire logic debug_mode_n_in,
    input wire logic [1:0] sync_phase_in,
    input wire logic sync_edge_in,
    output logic [7:0] byte_data_out,
    output logic byte_strobe_out,
    output logic fast_state_signal_out,
    output logic idle_out
);
    logic sim_async_clear_n;
    logic exec_sync;
    logic term_sync;
    logic [2:0] ripple_q, ripple_d;
    logic fx_smp_q, fx_smp_d, fx_hold_q, fx_hold_d, fx_out_q, fx_out_d;
    logic [dhs_pkg::VDS_STAGES:0] vd_q, vd_d;
    logic vd_neg_q;
    logic vd_out_q, vd_out_d;
    logic [2:0] cfg_s1_q, cfg_s2_q;
    logic rst_s1_q, rst_s2_q;
    // one bit per state
    logic ste_idle_q, ste_idle_d, ste_xfer_q, ste_xfer_d, ste_done_q, ste_done_d;
    logic state_bit_reset_n;
    logic fb_idle, fb_xfer, fb_done;
    logic cmp_q, cmp_d, tcm_q, tcm_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] dat_q, dat_d;
    logic stb_q, stb_d;
    logic start, abort;

    // -------------------------------------------
    // synchroniser clear
    // -------------------------------------------
    // both low together clears
    assign sim_async_clear_n = main_reset_n_in | debug_mode_n_in;

    // -------------------------------------------
    // fixed-delay synchroniser on execute
    // -------------------------------------------
    // 3-bit free counter; sampling every 8 ticks then two stages gives 9..17
    always_comb begin
        ripple_d = ripple_q + 3'h1;
        fx_smp_d = fx_smp_q;
        fx_hold_d = fx_hold_q;
        fx_out_d = fx_out_q;
        if (ripple_q == dhs_pkg::FDS_SMP_AT) begin
            fx_smp_d = link.transfer_request_toggle;
            fx_hold_d = fx_smp_q;
        end
        if (ripple_q == dhs_pkg::FDS_OUT_AT) begin
            fx_out_d = fx_hold_q;
        end
    end

    always_ff @(posedge clock_in or negedge sim_async_clear_n) begin
        if (!sim_async_clear_n) begin
            ripple_q <= dhs_pkg::FDS_CNT_RST;
            fx_smp_q <= dhs_pkg::TOGGLE_RST;
            fx_hold_q <= dhs_pkg::TOGGLE_RST;
            fx_out_q <= dhs_pkg::TOGGLE_RST;
        end else begin
            ripple_q <= ripple_d;
            fx_smp_q <= fx_smp_d;
            fx_hold_q <= fx_hold_d;
            fx_out_q <= fx_out_d;
        end
    end
    assign exec_sync = fx_out_q;

    // -------------------------------------------
    // variable-delay synchroniser on terminate
    // -------------------------------------------
    // config pins are static, but still cross in through two flops
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_s1_q <= {dhs_pkg::TOGGLE_RST, dhs_pkg::VDS_PHASE_RST};
            cfg_s2_q <= {dhs_pkg::TOGGLE_RST, dhs_pkg::VDS_PHASE_RST};
        end else begin
            cfg_s1_q <= {sync_edge_in, sync_phase_in};
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // edge choice only: a live change could glitch a sample
    always_ff @(negedge clock_in or negedge sim_async_clear_n) begin
        if (!sim_async_clear_n) begin
            vd_neg_q <= dhs_pkg::TOGGLE_RST;
        end else begin
            vd_neg_q <= link.terminate_request_toggle;
        end
    end

    always_comb begin
        vd_d = {vd_q[dhs_pkg::VDS_STAGES - 1:0], (cfg_s2_q[2] ? vd_neg_q : link.terminate_request_toggle)};
        // phase selects settled tap
        // taps 1..4 only: the capture stage itself is never read out
        vd_out_d = vd_q[{1'b0, cfg_s2_q[1:0]} + 3'h1];
    end

    always_ff @(posedge clock_in or negedge sim_async_clear_n) begin
        if (!sim_async_clear_n) begin
            vd_q <= {(dhs_pkg::VDS_STAGES + 1){dhs_pkg::TOGGLE_RST}};
            vd_out_q <= dhs_pkg::TOGGLE_RST;
        end else begin
            vd_q <= vd_d;
            vd_out_q <= vd_out_d;
        end
    end
    assign term_sync = vd_out_q;

    // -------------------------------------------
    // one-hot controller
    // -------------------------------------------
    // reset zeroes the xfer and done feedback terms; idle is forced set instead
    // release is taken on our clock so the feedback gates never see a ragged edge
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign state_bit_reset_n = rst_s2_q;
    assign fb_idle = ste_idle_q;
    assign fb_xfer = ste_xfer_q & state_bit_reset_n;
    assign fb_done = ste_done_q & state_bit_reset_n;
    assign start = fb_idle & (exec_sync != cmp_q);
    assign abort = (term_sync != tcm_q);

    always_comb begin
        ste_idle_d = ~state_bit_reset_n | (fb_idle & ~start) | fb_done;
        ste_xfer_d = start | (fb_xfer & ~abort & (cnt_q != dhs_pkg::OP_CNT_LAST));
        ste_done_d = fb_xfer & (abort | (cnt_q == dhs_pkg::OP_CNT_LAST));
        cnt_d = fb_xfer ? cnt_q + 3'h1 : dhs_pkg::OP_CNT_RST;
        dat_d = dat_q;
        stb_d = 1'b0;
        cmp_d = cmp_q;
        tcm_d = tcm_q;
        if (start) begin
            dat_d = link.wr_data;
        end
        if (fb_done) begin
            cmp_d = exec_sync;
            stb_d = 1'b1;
        end
        if (abort & ~fb_xfer) begin
            tcm_d = term_sync;
        end
    end

    // per-bit reset comes only through the next-state logic (feedback gating, idle forced set), so no async clear here
    always_ff @(posedge clock_in) begin
        ste_idle_q <= ste_idle_d;
        ste_xfer_q <= ste_xfer_d;
        ste_done_q <= ste_done_d;
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmp_q <= dhs_pkg::TOGGLE_RST;
            tcm_q <= dhs_pkg::TOGGLE_RST;
            cnt_q <= dhs_pkg::OP_CNT_RST;
            dat_q <= dhs_pkg::DATA_RST;
            stb_q <= 1'b0;
            fast_state_signal_out <= 1'b0;
            idle_out <= 1'b0;
        end else begin
            cmp_q <= cmp_d;
            tcm_q <= tcm_d;
            cnt_q <= cnt_d;
            dat_q <= dat_d;
            stb_q <= stb_d;
            fast_state_signal_out <= ste_xfer_d;
            idle_out <= ste_idle_d;
        end
    end

    assign link.transfer_complete_toggle = cmp_q;
    assign link.terminate_complete_toggle = tcm_q;
    assign link.rd_data = dat_q;
    assign byte_data_out = dat_q;
    assign byte_strobe_out = stb_q;
endmodule : dhs_server

/* File: verif/dhs_sva.sv */
`timescale 1ns/1ns
module dhs_sva (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic transfer_request_toggle,
    input wire logic transfer_complete_toggle,
    input wire logic terminate_request_toggle,
    input wire logic terminate_complete_toggle,
    input wire logic [7:0] wr_data
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // pending while the two transfer toggles differ
    wire pend = transfer_request_toggle != transfer_complete_toggle;
    AST_RST_EQUAL: assert property ($rose(rst_b_in) |-> !pend)
        else $error("transfer toggles differ after reset");
    AST_REQ_WHEN_EQUAL: assert property ($changed(transfer_request_toggle) |-> !$past(pend))
        else $error("request raised while pending");
    AST_REQ_HELD: assert property (pend |=> $stable(transfer_request_toggle))
        else $error("pending request withdrawn");
    AST_DATA_HELD: assert property (pend |=> $stable(wr_data))
        else $error("write data changed while pending");
    // the synchroniser alone costs at least 9 ticks
    AST_MIN_DELAY: assert property ($changed(transfer_request_toggle) |=> pend [*8])
        else $error("completion faster than synchroniser");
    AST_MAX_DELAY: assert property ($changed(transfer_request_toggle) |-> ##[1:40] !pend)
        else $error("transfer never completed");
    AST_COMP_COPIES: assert property ($changed(transfer_complete_toggle) |-> !pend)
        else $error("completion does not copy request");
    AST_TERM_ACK: assert property ($changed(terminate_request_toggle)
        |-> ##[1:20] terminate_complete_toggle == terminate_request_toggle)
        else $error("termination not acknowledged");
    cover property ($changed(transfer_complete_toggle));
    cover property ($changed(terminate_complete_toggle));
    cover property (pend && $changed(terminate_request_toggle));
endmodule : dhs_sva

/* File: verif/differential_handshake_sync_tb.sv */
`timescale 1ns/1ns
module differential_handshake_sync_tb;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic cmd_read_strobe_in = 1'b0;
    logic [3:0] cmd_addr_in = 4'h0;
    logic [7:0] cmd_data_in = 8'h00;
    logic drop_lock_in = 1'b0;
    logic main_reset_n_in = 1'b0;
    logic debug_mode_n_in = 1'b0;
    logic [1:0] sync_phase_in = 2'h0;
    logic sync_edge_in = 1'b0;
    logic busy_out, done_out, byte_strobe_out, fast_state_signal_out, idle_out;
    logic [7:0] result_out, byte_data_out;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] byte_q[$];
    logic [7:0] res_q[$];
    dhs_if link_if ();
    dhs_initiator u_dhs_initiator (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link_if),
        .cmd_read_strobe_in(cmd_read_strobe_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .drop_lock_in(drop_lock_in), .busy_out(busy_out), .done_out(done_out), .result_out(result_out));
    dhs_server u_dhs_server (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link_if),
        .main_reset_n_in(main_reset_n_in), .debug_mode_n_in(debug_mode_n_in), .sync_phase_in(sync_phase_in),
        .sync_edge_in(sync_edge_in), .byte_data_out(byte_data_out), .byte_strobe_out(byte_strobe_out),
        .fast_state_signal_out(fast_state_signal_out), .idle_out(idle_out));
    dhs_sva u_dhs_sva (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .transfer_request_toggle(link_if.transfer_request_toggle),
        .transfer_complete_toggle(link_if.transfer_complete_toggle),
        .terminate_request_toggle(link_if.terminate_request_toggle),
        .terminate_complete_toggle(link_if.terminate_complete_toggle), .wr_data(link_if.wr_data));
    always #50 clock_in = ~clock_in;
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s", $time, what);
        end
    endtask : check1
    task automatic stop_test();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // inputs move 1 ns after the rising edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic send(input logic [3:0] addr, input logic [7:0] data);
        tick(1);
        cmd_read_strobe_in = 1'b1;
        cmd_addr_in = addr;
        cmd_data_in = data;
        tick(1);
        cmd_read_strobe_in = 1'b0;
    endtask : send
    task automatic wait_done();
        int n;
        n = 0;
        while (done_out !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        if (n == 60) check1(1'b0, 1'b1, "no done");
        tick(2);
    endtask : wait_done
    // an empty queue means the design produced a result nobody asked for
    always @(posedge clock_in) begin
        if (byte_strobe_out === 1'b1) begin
            if (byte_q.size() == 0) check1(1'b0, 1'b1, "extra byte");
            else check8(byte_data_out, byte_q.pop_front(), "byte");
        end
        if (done_out === 1'b1) begin
            if (res_q.size() == 0) check1(1'b0, 1'b1, "extra done");
            else check8(result_out, res_q.pop_front(), "result");
        end
    end
    initial begin
        #(100 * 5000);
        mismatches++;
        stop_test();
    end
    initial begin
        logic [7:0] d;
        int i;
        int n;
        d = 8'($urandom(32'hc4c3));
        tick(10);
        main_reset_n_in = 1'b1;
        debug_mode_n_in = 1'b1;
        rst_b_in = 1'b1;
        tick(2);
        check1(idle_out, 1'b1, "idle");
        check1(link_if.transfer_request_toggle ^ link_if.transfer_complete_toggle, 1'b0, "pend");
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
            byte_q.push_back(d);
            res_q.push_back(d);
            send(4'h8, d);
            check1(busy_out, 1'b1, "busy");
            // synchroniser span plus the edge that enters the transfer state
            n = 0;
            while (fast_state_signal_out !== 1'b1 && n < 40) begin
                tick(1);
                n++;
            end
            check1(n >= dhs_pkg::FDS_MIN_TICKS + 1 && n <= dhs_pkg::FDS_MAX_TICKS + 1, 1'b1, "sync span");
            check1(idle_out, 1'b0, "idle beside transfer");
            wait_done();
        end
        $display("test transfer done");
        d = 8'($urandom());
        byte_q.push_back(d);
        res_q.push_back(d);
        send(4'h8, d);
        send(4'h8, ~d);
        wait_done();
        for (i = 0; i < 16; i++) if (i != 8) send(4'(i), 8'hA5);
        tick(40);
        check1(busy_out, 1'b0, "wrong address taken");
        // one of the two clear inputs alone must leave the synchronisers alone
        main_reset_n_in = 1'b0;
        tick(3);
        main_reset_n_in = 1'b1;
        debug_mode_n_in = 1'b0;
        tick(3);
        debug_mode_n_in = 1'b1;
        tick(30);
        check1(link_if.transfer_request_toggle ^ link_if.transfer_complete_toggle, 1'b0, "lone clear");
        $display("test refuse done");
        for (i = 0; i < 8; i++) begin
            sync_phase_in = 2'(i);
            sync_edge_in = i[2];
            if (i[0]) begin
                byte_q.push_back(8'h3C);
                res_q.push_back(8'h3C);
                send(4'h8, 8'h3C);
            end
            tick(3);
            drop_lock_in = 1'b1;
            tick(1);
            drop_lock_in = 1'b0;
            tick(12);
            check1(link_if.terminate_request_toggle ^ link_if.terminate_complete_toggle, 1'b0, "term");
            if (i[0]) wait_done();
            check1(link_if.transfer_request_toggle ^ link_if.transfer_complete_toggle, 1'b0, "abort");
        end
        $display("test terminate done");
        stop_test();
    end
endmodule : differential_handshake_sync_tb
